// ===== logic/ics_params.svh
`ifndef ICS_PARAMS_SVH
`define ICS_PARAMS_SVH

// Clock and timing
`define ICS_CLK_PERIOD_NS      25
`define ICS_FAST_WAKE_PERIODS  16
`define ICS_SLOW_WAKE_PERIODS  2
`define ICS_RUN_WAKE_PERIODS   2
`define ICS_SWITCH_PERIODS     16
`define ICS_POR_DELAY_MS       48
`define ICS_WDT_DELAY_MS       16
`define ICS_SWRST_MIN_US       90
`define ICS_SLOW_START_US      500
`define ICS_MS_CYCLES(ms)      ((ms) * 1000000 / `ICS_CLK_PERIOD_NS)
`define ICS_US_CYCLES(us)      (((us) * 1000 + `ICS_CLK_PERIOD_NS - 1) / `ICS_CLK_PERIOD_NS)

// Phase field position, program counter and page widths
`define ICS_PH_FETCH           0
`define ICS_PC_W               11
`define ICS_PAGE_W             8

`endif

// ===== logic/ics_pkg.sv
package ics_pkg;

  typedef enum logic [3:0] {
    ICS_PH1 = 4'h1,
    ICS_PH2 = 4'h2,
    ICS_PH3 = 4'h4,
    ICS_PH4 = 4'h8
  } ics_phase_t;

  typedef enum logic [2:0] {
    ICS_RUN  = 3'h1,
    ICS_HOLD = 3'h2,
    ICS_IDLE = 3'h4
  } ics_state_t;

  typedef enum logic [1:0] {
    ICS_OP_NORMAL = 2'h0,
    ICS_OP_BRANCH = 2'h1,
    ICS_OP_SKIP   = 2'h2,
    ICS_OP_PCLWR  = 2'h3
  } ics_op_t;

  typedef struct packed {
    logic        valid;
    ics_op_t     op;
    logic [10:0] target;
    logic [7:0]  pcl_data;
  } ics_exec_t;

endpackage

// ===== logic/ics_delay_cnt.sv
`include "ics_params.svh"

module ics_delay_cnt #(
  parameter int CW = 32
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          resetn_in,
  // Control
  input  wire logic          load_in,
  input  wire logic [CW-1:0] count_in,
  input  wire logic          tick_in,
  // Status
  output logic               busy_out
);
  logic [CW-1:0] cnt_q, cnt_d;

  // Refused at elaboration: a one-bit counter cannot hold a count and a busy state
  if (CW < 2) begin : g_bad_width
    $error("ics_delay_cnt width too small");
  end

  always_comb begin
    cnt_d = cnt_q;
    if (load_in) begin
      cnt_d = count_in;
    end else if (tick_in && cnt_q != '0) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_out = (cnt_q != '0);

endmodule

// ===== logic/ics_sequencer.sv
// Function
// - Four one-hot non-overlapping phases from core clock, fixed order.
// - Phase one advances program counter and starts next fetch.
// - Phases two to four decode and execute previous fetched word.
// - One full phase sequence is one instruction cycle.
// - Fetch of next overlaps execute of current; one per cycle.
// - Program counter changes cost one extra instruction cycle.
// - Branch takes two cycles: obtain target, then transfer control.
// - Stopped-clock wake waits 16 fast or 2 slow oscillator periods.
// - Running-clock wake waits 2 periods of selected clock.
// - Speed switch with fast oscillator start waits 16 fast periods.
// - Power-on reset holds execution 48 ms typical.
// - Watchdog timeout reset holds execution 16 ms typical.
// - Software reset request accepted only after 90 us persistent width.
// - Slow oscillator restart adds 500 us to wake delay when slow clock is selected.
// - Taken skip discards prefetched word, inserts idle cycle.
// - Low byte write jumps within 256-word page with idle cycle.
`include "ics_params.svh"

module ics_sequencer #(
  parameter int POR_CYCLES   = `ICS_MS_CYCLES(`ICS_POR_DELAY_MS),
  parameter int WDT_CYCLES   = `ICS_MS_CYCLES(`ICS_WDT_DELAY_MS),
  parameter int SWRST_CYCLES = `ICS_US_CYCLES(`ICS_SWRST_MIN_US),
  parameter int START_CYCLES = `ICS_US_CYCLES(`ICS_SLOW_START_US)
) (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  // Oscillator ticks and selection
  input  wire logic                       fast_internal_rc_osc_in,
  input  wire logic                       slow_internal_rc_osc_in,
  input  wire logic                       slow_sel_in,
  // Events
  input  wire logic                       por_in,
  input  wire logic                       watchdog_timeout_in,
  input  wire logic                       sw_reset_req_in,
  input  wire logic                       wake_in,
  input  wire logic                       wake_clk_off_in,
  input  wire logic                       slow_osc_was_off_in,
  input  wire logic                       speed_switch_in,
  // Executing instruction class
  input  wire ics_pkg::ics_exec_t         exec_in,
  // Outputs
  output ics_pkg::ics_phase_t             cycle_phase_clocks_out,
  output logic [`ICS_PC_W-1:0]            pc_out,
  output logic                            fetch_out,
  output logic                            exec_en_out,
  output logic                            run_out
);
  localparam int CW = 32;
  localparam int FAST_W = `ICS_FAST_WAKE_PERIODS;
  localparam int SLOW_W = `ICS_SLOW_WAKE_PERIODS;

  if (POR_CYCLES < 1 || WDT_CYCLES < 1 || SWRST_CYCLES < 1 || START_CYCLES < 1) begin : g_bad_cycles
    $error("ics_sequencer counts must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers (pins and oscillator ticks)
  logic [8:0] s1_q, s2_q, s3_q;
  logic       tick_fast, tick_slow, tick_sel;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {speed_switch_in, slow_osc_was_off_in, wake_clk_off_in, wake_in, sw_reset_req_in,
               watchdog_timeout_in, por_in, slow_internal_rc_osc_in, fast_internal_rc_osc_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Oscillators sampled as ticks on rising edge
  assign tick_fast = s2_q[0] & ~s3_q[0];
  assign tick_slow = s2_q[1] & ~s3_q[1];
  assign tick_sel  = slow_sel_in ? tick_slow : tick_fast;

  logic por_e, wdt_e, wake_e, sw_lvl, sw_e, sw_cnt_busy;
  assign por_e  = s2_q[2] & ~s3_q[2];
  assign wdt_e  = s2_q[3] & ~s3_q[3];
  assign sw_lvl = s2_q[4];
  assign wake_e = s2_q[5] & ~s3_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // Software reset width filter
  logic sw_seen_q, sw_seen_d;
  always_comb begin
    sw_seen_d = sw_seen_q;
    if (!sw_lvl) begin
      sw_seen_d = 1'b0;
    end else if (!sw_cnt_busy && sw_seen_q && sw_lvl) begin
      sw_seen_d = 1'b1;
    end else if (sw_lvl) begin
      sw_seen_d = 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sw_seen_q <= 1'b0;
    end else begin
      sw_seen_q <= sw_seen_d;
    end
  end
  // Counter restarts on each rising edge; short pulses end before it runs out
  ics_delay_cnt #(.CW(CW)) u_swrst (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (sw_lvl & ~sw_seen_q),
    .count_in  (CW'(SWRST_CYCLES)),
    .tick_in   (1'b1),
    .busy_out  (sw_cnt_busy)
  );
  logic sw_done_q, sw_done_d;
  always_comb begin
    sw_done_d = sw_lvl & sw_seen_q & ~sw_cnt_busy;
  end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sw_done_q <= 1'b0;
    end else begin
      sw_done_q <= sw_done_d;
    end
  end
  assign sw_e = sw_done_d & ~sw_done_q;

  // Checker only: length of the current request, saturating
  logic [CW-1:0] sw_len_q, sw_len_d;
  always_comb begin
    sw_len_d = sw_len_q;
    if (!sw_lvl) begin
      sw_len_d = '0;
    end else if (sw_len_q != '1) begin
      sw_len_d = sw_len_q + CW'(1);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sw_len_q <= '0;
    end else begin
      sw_len_q <= sw_len_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold-off delays
  logic          ms_load, osc_load, ms_busy, osc_busy;
  logic [CW-1:0] ms_count, osc_count;
  logic          stretch;
  always_comb begin
    ms_load  = por_e | wdt_e | sw_e | (wake_e & s2_q[7] & slow_sel_in);
    ms_count = CW'(START_CYCLES);
    if (por_e) begin
      ms_count = CW'(POR_CYCLES);
    end else if (wdt_e | sw_e) begin
      ms_count = CW'(WDT_CYCLES);
    end
    osc_load  = wake_e | s2_q[8];
    osc_count = CW'(SLOW_W);
    if (s2_q[8]) begin
      osc_count = CW'(`ICS_SWITCH_PERIODS);
    end else if (s2_q[6] && !slow_sel_in) begin
      osc_count = CW'(FAST_W);
    end
  end

  ics_delay_cnt #(.CW(CW)) u_msdly (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (ms_load),
    .count_in  (ms_count),
    .tick_in   (1'b1),
    .busy_out  (ms_busy)
  );
  // Osc delay waits for the slow restart first, then counts periods
  ics_delay_cnt #(.CW(CW)) u_oscdly (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (osc_load),
    .count_in  (s2_q[8] ? osc_count : osc_count),
    .tick_in   ((s2_q[8] ? tick_fast : tick_sel) & ~ms_busy),
    .busy_out  (osc_busy)
  );
  assign stretch = ms_busy | osc_busy | ms_load | osc_load;

  ////////////////////////////////////////////////////////////////////////////
  // Phase ring and pipeline
  ics_pkg::ics_phase_t ph_q, ph_d;
  ics_pkg::ics_state_t st_q, st_d;
  logic [`ICS_PC_W-1:0] pc_q, pc_d;
  logic fetch_q, fetch_d, exec_q, exec_d, run_q, run_d, pf_q, pf_d;

  always_comb begin
    ph_d    = ph_q;
    st_d    = st_q;
    pc_d    = pc_q;
    pf_d    = pf_q;
    fetch_d = 1'b0;
    exec_d  = 1'b0;
    run_d   = ~stretch;
    case (st_q)
      ics_pkg::ICS_HOLD: begin
        ph_d = ics_pkg::ICS_PH1;
        pf_d = 1'b0;
        if (!stretch) st_d = ics_pkg::ICS_RUN;
      end
      ics_pkg::ICS_RUN,
      ics_pkg::ICS_IDLE: begin
        case (ph_q)
          ics_pkg::ICS_PH1: ph_d = ics_pkg::ICS_PH2;
          ics_pkg::ICS_PH2: ph_d = ics_pkg::ICS_PH3;
          ics_pkg::ICS_PH3: ph_d = ics_pkg::ICS_PH4;
          default:          ph_d = ics_pkg::ICS_PH1;
        endcase
        // Next fetch starts with phase one, in parallel with execute
        if (ph_d == ics_pkg::ICS_PH1) begin
          pc_d    = pc_q + `ICS_PC_W'(1);
          fetch_d = 1'b1;
          pf_d    = 1'b1;
          st_d    = ics_pkg::ICS_RUN;
          if (st_q == ics_pkg::ICS_RUN && exec_in.valid && pf_q) begin
            case (exec_in.op)
              ics_pkg::ICS_OP_BRANCH: begin
                pc_d = exec_in.target;
                st_d = ics_pkg::ICS_IDLE;
                pf_d = 1'b0;
              end
              // Word fetched beside a change of flow is stale: drop it
              ics_pkg::ICS_OP_SKIP: begin
                st_d = ics_pkg::ICS_IDLE;
                pf_d = 1'b0;
              end
              ics_pkg::ICS_OP_PCLWR: begin
                pc_d = {pc_q[`ICS_PC_W-1:`ICS_PAGE_W], exec_in.pcl_data};
                st_d = ics_pkg::ICS_IDLE;
                pf_d = 1'b0;
              end
              default: st_d = ics_pkg::ICS_RUN;
            endcase
          end
        end
        if (ph_d != ics_pkg::ICS_PH1 && st_q == ics_pkg::ICS_RUN && pf_q) begin
          exec_d = 1'b1;
        end
        // Hold freezes fetch at once; a pending change of flow is dropped
        if (stretch) begin
          st_d    = ics_pkg::ICS_HOLD;
          pc_d    = pc_q;
          pf_d    = 1'b0;
          fetch_d = 1'b0;
          exec_d  = 1'b0;
        end
      end
      default: st_d = ics_pkg::ICS_HOLD;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ph_q    <= ics_pkg::ICS_PH1;
      st_q    <= ics_pkg::ICS_HOLD;
      pc_q    <= '0;
      pf_q    <= 1'b0;
      fetch_q <= 1'b0;
      exec_q  <= 1'b0;
      run_q   <= 1'b0;
    end else begin
      ph_q    <= ph_d;
      st_q    <= st_d;
      pc_q    <= pc_d;
      pf_q    <= pf_d;
      fetch_q <= fetch_d;
      exec_q  <= exec_d;
      run_q   <= run_d;
    end
  end

  assign cycle_phase_clocks_out = ph_q;
  assign pc_out                 = pc_q;
  assign fetch_out              = fetch_q;
  assign exec_en_out            = exec_q;
  assign run_out                = run_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence phase_ring_s;
    ph_q == ics_pkg::ICS_PH1 ##1 ph_q == ics_pkg::ICS_PH2 ##1 ph_q == ics_pkg::ICS_PH3
    ##1 ph_q == ics_pkg::ICS_PH4;
  endsequence

  phase_onehot_a: assert property (@(posedge clk_in) disable iff (!resetn_in) $onehot(ph_q))
    else $error("phase not one-hot");
  phase_order_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_q != ics_pkg::ICS_HOLD && ph_q == ics_pkg::ICS_PH1 && !stretch)
    |-> phase_ring_s or (##[1:3] st_q == ics_pkg::ICS_HOLD))
    else $error("phase order broken");
  fetch_phase_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fetch_q |-> ph_q == ics_pkg::ICS_PH1)
    else $error("fetch outside phase one");
  pc_advance_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (fetch_q && $past(st_q) == ics_pkg::ICS_RUN && !$past(exec_in.valid)) |-> pc_q == $past(pc_q) + `ICS_PC_W'(1))
    else $error("pc did not advance");
  exec_phase_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    exec_q |-> ph_q != ics_pkg::ICS_PH1)
    else $error("execute in fetch phase");
  branch_idle_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_q == ics_pkg::ICS_IDLE) |-> !exec_q)
    else $error("execute during idle cycle");
  page_jump_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_q == ics_pkg::ICS_IDLE && fetch_q && $past(exec_in.op) == ics_pkg::ICS_OP_PCLWR)
    |-> pc_q[`ICS_PC_W-1:`ICS_PAGE_W] == $past(pc_q[`ICS_PC_W-1:`ICS_PAGE_W]))
    else $error("page jump left page");
  hold_run_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    stretch |=> !run_q && !fetch_q)
    else $error("fetch during hold");
  sw_short_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sw_e |-> sw_len_q >= CW'(SWRST_CYCLES))
    else $error("software reset taken too early");

endmodule

// ===== tb/test_instruction_cycle_sequencer.sv
module test_instruction_cycle_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int k; logic sl, off, woff; int lo, hi;} ics_drow_t;
  typedef struct packed {ics_pkg::ics_op_t op; logic [10:0] tgt; logic [7:0] pc_low_byte;} ics_prow_t;

  logic                clk_in              = 1'b0;
  logic                resetn_in           = 1'b0;
  logic [3:0]          osc_cnt             = 4'h0;
  logic                slow_sel_in         = 1'b0;
  logic                por_in              = 1'b0;
  logic                watchdog_timeout_in = 1'b0;
  logic                sw_reset_req_in     = 1'b0;
  logic                wake_in             = 1'b0;
  logic                wake_clk_off_in     = 1'b0;
  logic                slow_osc_was_off_in = 1'b0;
  logic                speed_switch_in     = 1'b0;
  ics_pkg::ics_exec_t  exec_in             = '0;
  ics_pkg::ics_phase_t ph;
  logic [10:0]         pc_out;
  logic                fetch_out;
  logic                exec_en_out;
  logic                run_out;
  int                  fail_count          = 0;
  int                  check_count         = 0;
  logic [10:0]         exp_pc;
  logic                idle_q              = 1'b0;

  ics_sequencer #(.POR_CYCLES(20), .WDT_CYCLES(10), .SWRST_CYCLES(4), .START_CYCLES(8)) DUT (
    .clk_in                 (clk_in),
    .resetn_in              (resetn_in),
    .fast_internal_rc_osc_in(osc_cnt[1]),
    .slow_internal_rc_osc_in(osc_cnt[3]),
    .slow_sel_in            (slow_sel_in),
    .por_in                 (por_in),
    .watchdog_timeout_in    (watchdog_timeout_in),
    .sw_reset_req_in        (sw_reset_req_in),
    .wake_in                (wake_in),
    .wake_clk_off_in        (wake_clk_off_in),
    .slow_osc_was_off_in    (slow_osc_was_off_in),
    .speed_switch_in        (speed_switch_in),
    .exec_in                (exec_in),
    .cycle_phase_clocks_out (ph),
    .pc_out                 (pc_out),
    .fetch_out              (fetch_out),
    .exec_en_out            (exec_en_out),
    .run_out                (run_out)
  );

  always #12.5 clk_in = ~clk_in;

  // Free-running oscillators: fast period 4 clocks, slow period 16
  always @(posedge clk_in) begin
    osc_cnt <= #2 osc_cnt + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_in);
    #2;
  endtask

  task automatic ev(input int k, input logic v);
    case (k)
      0: por_in = v;
      1: watchdog_timeout_in = v;
      2: sw_reset_req_in = v;
      3: wake_in = v;
      default: speed_switch_in = v;
    endcase
  endtask

  // Event held until the hold-off starts, then span of run low measured
  task automatic run_delay(input ics_drow_t r);
    int n;
    slow_sel_in = r.sl;
    wake_clk_off_in = r.off;
    slow_osc_was_off_in = r.woff;
    repeat (4) tick();
    ev(r.k, 1'b1);
    n = 0;
    while (run_out === 1'b1 && n < 40) begin tick(); n++; end
    ev(r.k, 1'b0);
    chk(11'(n < 40), 11'h1);
    n = 0;
    while (run_out !== 1'b1 && n < 200) begin
      chk({9'h0, fetch_out, exec_en_out}, 11'h0);
      tick();
      n++;
    end
    chk(11'(n >= r.lo && n <= r.hi), 11'h1);
    slow_sel_in = 1'b0;
    $display("Test delay kind %0d done", r.k);
  endtask

  // Model: one idle cycle after a taken change of flow, request ignored there
  task automatic step(input ics_prow_t r);
    int n;
    logic idle;
    n = 0;
    while (ph !== ics_pkg::ICS_PH4 && n < 8) begin tick(); n++; end
    exec_in = '{1'b1, r.op, r.tgt, r.pc_low_byte};
    idle = 1'b0;
    if (idle_q) begin
      exp_pc = exp_pc + 11'h1;
    end else begin
      case (r.op)
        ics_pkg::ICS_OP_NORMAL: exp_pc = exp_pc + 11'h1;
        ics_pkg::ICS_OP_BRANCH: begin exp_pc = r.tgt; idle = 1'b1; end
        ics_pkg::ICS_OP_SKIP:   begin exp_pc = exp_pc + 11'h1; idle = 1'b1; end
        default:                begin exp_pc = {exp_pc[10:8], r.pc_low_byte}; idle = 1'b1; end
      endcase
    end
    tick();
    exec_in = '0;
    chk({7'h0, ph}, 11'h1);
    chk({10'h0, fetch_out}, 11'h1);
    chk(pc_out, exp_pc);
    tick();
    chk({10'h0, exec_en_out}, {10'h0, !idle});
    idle_q = idle;
  endtask

  task automatic reset_test();
    resetn_in = 1'b0;
    repeat (6) tick();
    chk({ph, pc_out[6:0]}, 11'h080);
    chk({8'h0, fetch_out, exec_en_out, run_out}, 11'h0);
    resetn_in = 1'b1;
    tick();
    tick();
    chk({10'h0, run_out}, 11'h1);
    while (ph !== ics_pkg::ICS_PH1) tick();
    for (int i = 0; i < 8; i++) begin
      chk({7'h0, ph}, 11'(1 << (i % 4)));
      chk({10'h0, fetch_out}, 11'(i % 4 == 0));
      if (i % 4 != 0) chk({10'h0, exec_en_out}, 11'h1);
      tick();
    end
    $display("Test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  ics_drow_t drows[9] = '{
    '{0, 0, 0, 0, 19, 30},
    '{1, 0, 0, 0, 9, 20},
    '{2, 0, 0, 0, 9, 20},
    '{3, 0, 1, 0, 60, 80},
    // Slow rows: first period is partial, so the span covers one slow period of phase
    '{3, 1, 1, 0, 17, 36},
    '{3, 1, 1, 1, 25, 44},
    '{3, 0, 0, 0, 6, 16},
    '{3, 1, 0, 0, 17, 36},
    '{4, 0, 0, 0, 60, 80}
  };

  ics_prow_t prows[11] = '{
    '{ics_pkg::ICS_OP_NORMAL, 11'h000, 8'h00},
    '{ics_pkg::ICS_OP_NORMAL, 11'h000, 8'h00},
    '{ics_pkg::ICS_OP_BRANCH, 11'h123, 8'h00},
    '{ics_pkg::ICS_OP_BRANCH, 11'h456, 8'h00},
    '{ics_pkg::ICS_OP_PCLWR,  11'h000, 8'h5a},
    '{ics_pkg::ICS_OP_NORMAL, 11'h000, 8'h00},
    '{ics_pkg::ICS_OP_SKIP,   11'h000, 8'h00},
    '{ics_pkg::ICS_OP_SKIP,   11'h000, 8'h00},
    '{ics_pkg::ICS_OP_BRANCH, 11'h7ff, 8'h00},
    '{ics_pkg::ICS_OP_NORMAL, 11'h000, 8'h00},
    '{ics_pkg::ICS_OP_NORMAL, 11'h000, 8'h00}
  };

  initial begin
    #500000;
    fail_count++;
    complete_run();
  end

  initial begin
    reset_test();
    foreach (drows[i]) run_delay(drows[i]);
    repeat (8) tick();
    // Base address taken once; every later address comes from the model
    while (ph !== ics_pkg::ICS_PH4) tick();
    exp_pc = pc_out;
    foreach (prows[i]) step(prows[i]);
    $display("Test pipeline done");
    // Too-short software request must not stop execution
    sw_reset_req_in = 1'b1;
    tick();
    tick();
    sw_reset_req_in = 1'b0;
    repeat (20) begin
      chk({10'h0, run_out}, 11'h1);
      tick();
    end
    $display("Test short request done");
    reset_test();
    complete_run();
  end
endmodule
